//--- hw/virl_top.sv
// Interrupt request, mask and priority registers with the vectored interrupt sequencer.
`timescale 1ns/1ns
`default_nettype none
module virl_top
    import virl_pkg::*;
(
    // Clock and reset.
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // External request pins, falling-edge triggered.
    input  wire logic [5:0] ext_req_pin_in,
    // Internal request pulses from on-chip sources.
    input  wire logic [5:0] int_req_in,
    // Register-file access from the core.
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Instruction sequencer events.
    input  wire logic       sample_in,
    input  wire logic       global_enable_instr_in,
    input  wire logic       global_mask_off_instr_in,
    input  wire logic       return_from_handler_instr_in,
    // Interrupt cycle handshake.
    output logic            irq_take_out,
    input  wire logic       cycle_ack_in,
    input  wire logic       step_done_in,
    // Stack push and vector fetch requests.
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0] flags_in,
    output logic            push_out,
    output logic      [7:0] push_data_out,
    output logic            fetch_out,
    output logic      [7:0] fetch_addr_out,
    input  wire logic [7:0] fetch_data_in,
    output logic            branch_out,
    output logic     [15:0] branch_addr_out,
    output logic      [2:0] level_out
);
    logic [5:0]  ext_fall;        // Synchronised external edges.
    logic [5:0]  latch_q;         // First flop: caught requests awaiting sampling.
    logic [5:0]  pend_q;          // Pending request register.
    logic        released_q;      // Set by the first global enable; ends the reset hold.
    logic [5:0]  mask_q;          // Per-level enables.
    logic        master_q;        // Master enable.
    logic [7:0]  prio_q;          // Priority select pattern.
    logic        any_win;         // A level is eligible.
    logic [2:0]  win_lvl;         // Winning level.
    virl_state_t st_q;            // Sequencer state.
    logic [2:0]  lvl_q;           // Level being serviced.
    logic [7:0]  vec_hi_q;        // Fetched upper vector byte.
    logic        wr_pend;
    logic        wr_mask;
    logic        wr_prio;
    logic        take;
    logic [5:0]  pend_d;          // Next value of the pending register.

    // Address decode for the writable registers.
    // Each write is a one-cycle strobe from the core.
    // The full address is compared, so nothing aliases.
    assign wr_pend = reg_wr_in && (reg_addr_in == VIRL_ADDR_PEND);
    assign wr_mask = reg_wr_in && (reg_addr_in == VIRL_ADDR_MASK);
    assign wr_prio = reg_wr_in && (reg_addr_in == VIRL_ADDR_PRIO);

    // Edge filter for the pin sources.
    // The chain adds a few clocks of delay to pin edges.
    // Internal pulses skip it, as they share our clock.
    // A pin request can therefore miss one sample point.
    virl_sync u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .pin_in      (ext_req_pin_in),
        .fall_out    (ext_fall)
    );

    // Priority resolution over enabled pending levels.
    // Masked and globally disabled levels never compete.
    // The winner is registered to keep the take path short.
    // The cost is one clock between a request and the take.
    virl_prio u_prio (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .req_in      (pend_q & mask_q & {VIRL_LEVELS{master_q}}),
        .prio_in     (prio_q),
        .any_out     (any_win),
        .level_out   (win_lvl)
    );

    // Caught requests stay in the first flop until the next sample point.
    // Sampling empties the catch flop in the same edge.
    // A request arriving at that edge is kept, not lost.
    // Requests keep being caught during the reset hold.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            latch_q <= VIRL_PEND_RST;
        end else begin
            latch_q <= (sample_in ? 6'h00 : latch_q) | ext_fall | int_req_in;
        end
    end

    // The hold lifts once the first global enable executes.
    // Only a hardware reset puts the hold back on.
    // Polled software must still issue one global enable.
    // Until then every pending write is dropped.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            released_q <= 1'b0;
        end else if (global_enable_instr_in) begin
            released_q <= 1'b1;
        end
    end

    // Next pending value: software write, interrupt-cycle clear,
    // then sampled requests on top.
    // A software write replaces the whole register; request sources only set bits.
    always_comb begin
        pend_d = pend_q;
        if (wr_pend) begin
            pend_d = reg_wdata_in[5:0];
        end
        if (take) begin
            pend_d[win_lvl] = 1'b0;
        end
        // Setting last means a request wins over a same-cycle clear.
        if (sample_in) begin
            pend_d = pend_d | latch_q;
        end
    end

    // Pending register, held clear until the first global enable.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !released_q) begin
            pend_q <= VIRL_PEND_RST;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Mask and priority registers; their low bits have no defined reset value.
    // Leaving out the reset saves flops on these bits.
    // Software must write both before any level is unmasked.
    // Until then the master enable keeps requests blocked.
    // The priority pattern can only be written, never read.
    always_ff @(posedge core_clk_in) begin
        if (wr_mask) begin
            mask_q <= reg_wdata_in[5:0];
        end
        if (wr_prio) begin
            prio_q <= reg_wdata_in;
        end
    end

    // Master enable: instructions, software write, and the interrupt cycle.
    // The interrupt cycle wins so a handler starts disabled.
    // A return or global enable sets it again.
    // A plain mask write also moves it through bit seven.
    // Software should disable before changing mask or order.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            master_q <= VIRL_MASTER_RST;
        end else if (take) begin
            master_q <= 1'b0;
        end else if (global_enable_instr_in || return_from_handler_instr_in) begin
            master_q <= 1'b1;
        end else if (global_mask_off_instr_in) begin
            master_q <= 1'b0;
        end else if (wr_mask) begin
            master_q <= reg_wdata_in[VIRL_MASTER_BIT];
        end
    end

    // Registered read data; unimplemented bits read zero.
    // Data follow the address by one clock.
    // Unmapped and write-only addresses read as zero.
    // The read has no side effect on any flag.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            case (reg_addr_in)
                VIRL_ADDR_PEND: reg_rdata_out <= {2'b00, pend_q};
                VIRL_ADDR_MASK: reg_rdata_out <= {master_q, 1'b0, mask_q};
                default:        reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Request the core once a level wins; accepted with cycle_ack_in. A soft request
    // reaches here through the same path as a pin request.
    // The take is not held; it drops if the winner or the master enable goes before the acknowledge.
    // The sequence must be idle, so no take nests in hardware.
    // Nesting is left to handler software.
    assign irq_take_out = any_win && master_q && (st_q == VIRL_IDLE);
    assign take         = irq_take_out && cycle_ack_in;

    // Vectored sequence: three pushes, two vector fetches, then branch.
    // Every push and fetch step waits for the core's done pulse; the branch state lasts one clock.
    // A slow stack or memory only stretches the step.
    // The serviced level is frozen at the take.
    // Later requests cannot change the vector mid-sequence.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_q     <= VIRL_IDLE;
            lvl_q    <= 3'd0;
            vec_hi_q <= 8'h00;
        end else begin
            case (st_q)
                VIRL_IDLE: begin
                    if (take) begin
                        lvl_q <= win_lvl;
                        st_q  <= VIRL_PUSH_PCL;
                    end
                end
                VIRL_PUSH_PCL:   if (step_done_in) st_q <= VIRL_PUSH_PCH;
                VIRL_PUSH_PCH:   if (step_done_in) st_q <= VIRL_PUSH_FLAGS;
                VIRL_PUSH_FLAGS: if (step_done_in) st_q <= VIRL_FETCH_HI;
                VIRL_FETCH_HI: begin
                    if (step_done_in) begin
                        vec_hi_q <= fetch_data_in;
                        st_q     <= VIRL_FETCH_LO;
                    end
                end
                VIRL_FETCH_LO:   if (step_done_in) st_q <= VIRL_BRANCH;
                VIRL_BRANCH:     st_q <= VIRL_IDLE;
                default:         st_q <= VIRL_IDLE;
            endcase
        end
    end

    // Branch target register loads on the low vector byte.
    // It is valid in the branch cycle and holds afterwards.
    // The upper byte was kept from the earlier fetch.
    // Both bytes come from this level's vector slot.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            branch_addr_out <= 16'h0000;
        end else if (st_q == VIRL_FETCH_LO && step_done_in) begin
            branch_addr_out <= {vec_hi_q, fetch_data_in};
        end
    end

    // Step outputs derived from the state.
    // These are combinational so a step starts at once.
    // The core samples them only while the strobe is up.
    // Idle states show zero data to keep the bus quiet.
    // Vectors sit in pairs: upper byte even, lower byte odd.
    always_comb begin
        push_out       = 1'b0;
        push_data_out  = 8'h00;
        fetch_out      = 1'b0;
        fetch_addr_out = 8'h00;
        case (st_q)
            VIRL_PUSH_PCL: begin
                push_out      = 1'b1;
                push_data_out = pc_in[7:0];
            end
            VIRL_PUSH_PCH: begin
                push_out      = 1'b1;
                push_data_out = pc_in[15:8];
            end
            VIRL_PUSH_FLAGS: begin
                push_out      = 1'b1;
                push_data_out = flags_in;
            end
            VIRL_FETCH_HI: begin
                fetch_out      = 1'b1;
                fetch_addr_out = VIRL_VEC_BASE + {4'h0, lvl_q, 1'b0};
            end
            VIRL_FETCH_LO: begin
                fetch_out      = 1'b1;
                fetch_addr_out = VIRL_VEC_BASE + {4'h0, lvl_q, 1'b1};
            end
            default: begin
                push_out = 1'b0;
            end
        endcase
    end

    // The branch pulse lasts one clock in the branch state.
    // The serviced level stays visible until the next take.
    // Software may read it to share one handler.
    assign branch_out = (st_q == VIRL_BRANCH);
    assign level_out  = lvl_q;
endmodule
`default_nettype wire

//--- include/virl_pkg.sv
// Package with register addresses, reset values and sequence states for the interrupt request logic.
// Contract
// - One pending bit per level zero to five.
// - Pending register readable, writable at address FA.
// - Pending bits held clear until first enable.
// - Pending bits six and seven read zero.
// - Software-set bits act like hardware requests.
// - Software request vectors when enabled and highest.
// - Each level has its own vector.
// - Push PC low, PC high, flags; fetch vector.
// - Masked levels still latch requests for polling.
// - Master enable bit seven clears at reset.
// - Mask bit six reads zero.
// - Priority register undefined after reset.
// - Bit seven is master enable, set by instructions.
// - Interrupt cycle clears master; return sets it.
// - Interrupt cycle clears only winning pending bit.
// - Requests sampled in last cycle before fetch.
`default_nettype none
package virl_pkg;
    // Register-file addresses of the three interrupt registers.
    localparam logic [7:0] VIRL_ADDR_PEND  = 8'hfa;
    localparam logic [7:0] VIRL_ADDR_MASK  = 8'hfb;
    localparam logic [7:0] VIRL_ADDR_PRIO  = 8'hf9;
    // Field positions and reset values.
    localparam int         VIRL_LEVELS     = 6;
    localparam int         VIRL_MASTER_BIT = 7;
    localparam logic [5:0] VIRL_PEND_RST   = 6'h00;
    localparam logic       VIRL_MASTER_RST = 1'b0;
    localparam logic [7:0] VIRL_VEC_BASE   = 8'h00;
    // Sequence steps of the vectored interrupt cycle.
    typedef enum logic [2:0] {
        VIRL_IDLE,
        VIRL_PUSH_PCL,
        VIRL_PUSH_PCH,
        VIRL_PUSH_FLAGS,
        VIRL_FETCH_HI,
        VIRL_FETCH_LO,
        VIRL_BRANCH
    } virl_state_t;
endpackage
`default_nettype wire

//--- hw/virl_sync.sv
// Three-stage synchroniser with agreement filter for edge-triggered request pins.
`timescale 1ns/1ns
`default_nettype none
module virl_sync
    import virl_pkg::*;
(
    // Clock and reset.
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // Raw pins and filtered falling-edge pulses.
    input  wire logic [5:0] pin_in,
    output logic      [5:0] fall_out
);
    logic [5:0] s1_q;    // First stage, read only by the second.
    logic [5:0] s2_q;    // Second stage.
    logic [5:0] s3_q;    // Third stage.
    logic [5:0] lvl_q;   // Accepted level once stages two and three agree.

    // Shift the pins through three flops; idle level is high.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s1_q  <= 6'h3f;
            s2_q  <= 6'h3f;
            s3_q  <= 6'h3f;
            lvl_q <= 6'h3f;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // A change counts only when the later stages agree.
            lvl_q <= (s2_q == s3_q) ? s3_q : lvl_q;
        end
    end

    // A falling accepted level is one request event.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            fall_out <= 6'h00;
        end else begin
            fall_out <= lvl_q & ~((s2_q == s3_q) ? s3_q : lvl_q);
        end
    end
endmodule
`default_nettype wire

//--- hw/virl_prio.sv
// Priority resolver: picks the winning enabled level from the priority select pattern.
`timescale 1ns/1ns
`default_nettype none
module virl_prio
    import virl_pkg::*;
(
    // Clock and reset.
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // Enabled pending levels and priority select.
    input  wire logic [5:0] req_in,
    input  wire logic [7:0] prio_in,
    // Registered winner.
    output logic            any_out,
    output logic      [2:0] level_out
);
    // Order one group's pair by its select bit; first element wins.
    function automatic logic [5:0] pair_ord(input logic sel, input logic [2:0] a, input logic [2:0] b);
        pair_ord = sel ? {b, a} : {a, b};
    endfunction

    logic [5:0]  grp_a;   // Levels 5 and 3.
    logic [5:0]  grp_b;   // Levels 2 and 0.
    logic [5:0]  grp_c;   // Levels 1 and 4.
    logic [17:0] order;   // Six levels, highest first in the top bits.
    logic        hit;
    logic [2:0]  win;

    // Build the full order and pick the first pending level.
    always_comb begin
        grp_a = pair_ord(prio_in[5], 3'd5, 3'd3);
        grp_b = pair_ord(prio_in[2], 3'd2, 3'd0);
        grp_c = pair_ord(prio_in[1], 3'd1, 3'd4);
        case ({prio_in[4], prio_in[3], prio_in[0]})
            3'b001:  order = {grp_c, grp_a, grp_b};
            3'b010:  order = {grp_a, grp_b, grp_c};
            3'b011:  order = {grp_a, grp_c, grp_b};
            3'b100:  order = {grp_b, grp_c, grp_a};
            3'b101:  order = {grp_c, grp_b, grp_a};
            3'b110:  order = {grp_b, grp_a, grp_c};
            // Unused patterns fall back to a fixed order so nothing stalls.
            default: order = {grp_a, grp_b, grp_c};
        endcase
        hit = 1'b0;
        win = 3'd0;
        for (int i = 5; i >= 0; i--) begin
            if (!hit && req_in[order[i*3 +: 3]]) begin
                hit = 1'b1;
                win = order[i*3 +: 3];
            end
        end
    end

    // Register the winner for the sequencer.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            any_out   <= 1'b0;
            level_out <= 3'd0;
        end else begin
            any_out   <= hit;
            level_out <= win;
        end
    end
endmodule
`default_nettype wire

//--- dv/virl_chk.sv
// Concurrent checks on the ports of the interrupt request logic.
`timescale 1ns/1ns
`default_nettype none
module virl_chk (
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    // Watched ports.
    input  wire logic        global_mask_off_instr_in,
    input  wire logic        irq_take_out,
    input  wire logic        cycle_ack_in,
    input  wire logic        step_done_in,
    input  wire logic [15:0] pc_in,
    input  wire logic        push_out,
    input  wire logic  [7:0] push_data_out,
    input  wire logic        fetch_out,
    input  wire logic  [7:0] fetch_addr_out,
    input  wire logic        branch_out,
    input  wire logic  [2:0] level_out
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_take_when_idle: assert property (irq_take_out |-> !push_out && !fetch_out && !branch_out)
        else $error("take raised during a sequence");
    chk_ack_push_low: assert property (irq_take_out && cycle_ack_in |=> push_out && push_data_out == pc_in[7:0])
        else $error("first push is not the low pc byte");
    chk_low_then_high: assert property (push_out && step_done_in && push_data_out == pc_in[7:0]
        |=> push_out && push_data_out == pc_in[15:8]) else $error("high pc byte does not follow");
    chk_push_holds: assert property (push_out && !step_done_in |=> push_out && $stable(push_data_out))
        else $error("push dropped before step done");
    chk_vector_addr: assert property (fetch_out |-> fetch_addr_out[7:1] == {4'h0, level_out})
        else $error("vector address not tied to level");
    chk_hi_then_lo: assert property (fetch_out && step_done_in && !fetch_addr_out[0] |=> fetch_out && fetch_addr_out[0])
        else $error("low vector byte does not follow");
    chk_lo_then_branch: assert property (fetch_out && step_done_in && fetch_addr_out[0] |=> branch_out ##1 !branch_out)
        else $error("branch pulse missing after vector");
    chk_no_retake: assert property (irq_take_out && cycle_ack_in |=> !irq_take_out [*6])
        else $error("take raised again inside the sequence");
    chk_mask_off_quiet: assert property (global_mask_off_instr_in |-> ##2 !irq_take_out)
        else $error("take raised after global disable");
    chk_reset_quiet: assert property ($fell(sys_rst_in) |-> !irq_take_out && !push_out && !fetch_out)
        else $error("outputs busy after reset");
    // Main scenarios that the bench should reach.
    cover property (irq_take_out && cycle_ack_in);
    cover property (branch_out);
    cover property (global_mask_off_instr_in);
endmodule
`default_nettype wire

//--- dv/virl_core_model.sv
// Behavioural core sequencer that answers the interrupt cycle handshake.
`timescale 1ns/1ns
`default_nettype none
module virl_core_model (
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    // Extra wait cycles for each step, so slow answers are exercised too.
    input  wire logic  [3:0] slow_in,
    // Requests from the block.
    input  wire logic        irq_take_in,
    input  wire logic        push_in,
    input  wire logic  [7:0] push_data_in,
    input  wire logic        fetch_in,
    input  wire logic  [7:0] fetch_addr_in,
    // Answers to the block.
    output logic             cycle_ack_out,
    output logic             step_done_out,
    output logic       [7:0] fetch_data_out,
    output logic      [23:0] pushed_out
);
    logic [3:0] wait_q;  // Cycles waited in the current step.
    logic [7:0] noise_q; // Changing byte shown when no fetch is asked.
    // A vector byte is the inverted address; outside fetches and reset the bus never keeps its last value.
    assign fetch_data_out = fetch_in ? ~fetch_addr_in : noise_q;
    // Accept the take once and end each step after the chosen wait.
    always_ff @(posedge core_clk_in) begin
        cycle_ack_out <= 1'b0;
        step_done_out <= 1'b0;
        noise_q <= noise_q + 8'h3b;
        if (sys_rst_in) begin
            wait_q <= 4'h0;
            noise_q <= 8'h00;
        end else if ((push_in || fetch_in) && !step_done_out) begin
            if (wait_q == slow_in) begin
                step_done_out <= 1'b1;
                wait_q <= 4'h0;
                if (push_in) begin
                    pushed_out <= {pushed_out[15:0], push_data_in};
                end
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
        if (irq_take_in && !cycle_ack_out && !sys_rst_in) begin
            cycle_ack_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- dv/test_vectored_interrupt_request_logic.sv
// Self-checking bench for the vectored interrupt request logic.
`timescale 1ns/1ns
`default_nettype none
module test_vectored_interrupt_request_logic;
    import virl_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, smp = 1'b0, ge = 1'b0, gd = 1'b0, rt = 1'b0;
    logic  [5:0] ext = 6'h3f, irq = 6'h00;
    logic  [7:0] addr = 8'h00, wdata = 8'h00;
    logic  [3:0] slow = 4'h0;
    wire logic        take, ack, done, push, fetch, br;
    wire logic  [7:0] rdata, pdata, faddr, fdata;
    wire logic [15:0] baddr;
    wire logic  [2:0] lvl;
    wire logic [23:0] pushed;
    int n_fail = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    virl_top dut (.core_clk_in(clk), .sys_rst_in(rst), .ext_req_pin_in(ext), .int_req_in(irq), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .sample_in(smp), .global_enable_instr_in(ge),
        .global_mask_off_instr_in(gd), .return_from_handler_instr_in(rt), .irq_take_out(take), .cycle_ack_in(ack),
        .step_done_in(done), .pc_in(16'h1234), .flags_in(8'h5a), .push_out(push), .push_data_out(pdata),
        .fetch_out(fetch), .fetch_addr_out(faddr), .fetch_data_in(fdata), .branch_out(br), .branch_addr_out(baddr),
        .level_out(lvl));
    virl_core_model u_core (.core_clk_in(clk), .sys_rst_in(rst), .slow_in(slow), .irq_take_in(take), .push_in(push),
        .push_data_in(pdata), .fetch_in(fetch), .fetch_addr_in(faddr), .cycle_ack_out(ack), .step_done_out(done),
        .fetch_data_out(fdata), .pushed_out(pushed));
    // Inputs always change 2 ns after a rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    // Read data is registered, so it is judged one edge after the address; m hides undefined bits.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        addr = a;
        tick(1);
        chk(rdata & m, e);
    endtask
    // Pulse one sequencer event: 4 enable, 2 disable, 1 return.
    task automatic ev(input logic [2:0] k);
        {ge, gd, rt} = k;
        tick(1);
        {ge, gd, rt} = 3'b000;
        tick(1);
    endtask
    task automatic wait_branch(input logic [15:0] va, input logic [2:0] lv);
        int i;
        for (i = 0; i < 100 && br !== 1'b1; i++) tick(1);
        chk(br, 1'b1);
        chk(baddr, va);
        chk(lvl, lv);
    endtask
    task automatic t_reset();
        rd(VIRL_ADDR_PEND, 8'hff, 8'h00);
        rd(VIRL_ADDR_MASK, 8'hc0, 8'h00);
        rd(8'h10, 8'hff, 8'h00);
        wr_reg(VIRL_ADDR_PEND, 8'h3f);
        rd(VIRL_ADDR_PEND, 8'hff, 8'h00);
        chk(take, 1'b0);
    endtask
    task automatic t_poll();
        wr_reg(VIRL_ADDR_MASK, 8'h00);
        ev(3'b100);
        ev(3'b010);
        irq = 6'h04;
        tick(1);
        {irq, smp} = 7'h01;
        tick(1);
        smp = 1'b0;
        rd(VIRL_ADDR_PEND, 8'hff, 8'h04);
        chk(take, 1'b0);
        ext = 6'h3e;
        tick(6);
        smp = 1'b1;
        tick(1);
        {ext, smp} = 7'h7e;
        rd(VIRL_ADDR_PEND, 8'hff, 8'h05);
        wr_reg(VIRL_ADDR_PEND, 8'hff);
        rd(VIRL_ADDR_PEND, 8'hff, 8'h3f);
        irq = 6'h08;
        tick(1);
        {irq, smp} = 7'h01;
        wr_reg(VIRL_ADDR_PEND, 8'h00);
        smp = 1'b0;
        rd(VIRL_ADDR_PEND, 8'hff, 8'h08);
        wr_reg(VIRL_ADDR_PEND, 8'h00);
        rd(VIRL_ADDR_PEND, 8'hff, 8'h00);
    endtask
    // Two soft requests; level 5 wins under this priority pattern, then level 1 is taken after the return.
    task automatic t_vector();
        wr_reg(VIRL_ADDR_PRIO, 8'h04);
        wr_reg(VIRL_ADDR_MASK, 8'h22);
        ev(3'b100);
        rd(VIRL_ADDR_MASK, 8'hff, 8'ha2);
        wr_reg(VIRL_ADDR_PEND, 8'h22);
        wait_branch(16'hf5f4, 3'h5);
        chk(pushed, 24'h34125a);
        rd(VIRL_ADDR_PEND, 8'hff, 8'h02);
        rd(VIRL_ADDR_MASK, 8'hff, 8'h22);
        wr_reg(VIRL_ADDR_MASK, 8'h20);
        ev(3'b100);
        tick(4);
        chk(take, 1'b0);
        ev(3'b010);
        rd(VIRL_ADDR_MASK, 8'hff, 8'h20);
        wr_reg(VIRL_ADDR_MASK, 8'h22);
        slow = 4'h3;
        ev(3'b001);
        wait_branch(16'hfdfc, 3'h1);
        rd(VIRL_ADDR_PEND, 8'hff, 8'h00);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        rst = 1'b0;
        t_reset();
        t_poll();
        t_vector();
        summarize();
    end
    // The tests need well under a thousand cycles; 200 us is a generous ceiling.
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule
bind virl_top virl_chk u_chk (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .global_mask_off_instr_in(global_mask_off_instr_in), .irq_take_out(irq_take_out), .cycle_ack_in(cycle_ack_in),
    .step_done_in(step_done_in), .pc_in(pc_in), .push_out(push_out), .push_data_out(push_data_out),
    .fetch_out(fetch_out), .fetch_addr_out(fetch_addr_out), .branch_out(branch_out), .level_out(level_out));
`default_nettype wire
